/* rtl/close_onto_fault_trip.sv */
// Purpose: Close-onto-fault trip stage with register port and interrupt.
// Assumes: Phase magnitudes in milli per-unit arrive on i_clk; digital inputs are async pins.
// Notes:   Trip holds until the breaker is seen open again or the stage is disabled.
`timescale 1ns/1ps
`include "cof_defs.svh"
module close_onto_fault_trip
  import cof_pkg::*;
#(
  parameter int unsigned MS_TICK_CYC = `COF_MS_TICK_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Phase current magnitudes
  input wire logic [15:0] i_cur_l1,
  input wire logic [15:0] i_cur_l2,
  input wire logic [15:0] i_cur_l3,
  // Breaker-open inputs
  input wire logic [7:0] i_digital_input_select,
  input wire logic [7:0] i_virtual_input_select,
  // Results
  output logic o_trip,
  output logic [1:0] o_status,
  output logic o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [15:0] max3(input logic [15:0] a, input logic [15:0] b,
                                       input logic [15:0] c);
    logic [15:0] m;
    m = (a > b) ? a : b;
    return (m > c) ? m : c;
  endfunction

  function automatic logic [1:0] status_of(input fsm_t s);
    logic [1:0] v;
    v = `COF_STAT_BLOCKED;
    if (s == ST_TRIP) begin
      v = `COF_STAT_TRIPPED;
    end else if (s == ST_ARMED || s == ST_ACTIVE) begin
      v = `COF_STAT_STARTED;
    end
    return v;
  endfunction

  localparam core_t CORE_RST = '{
    state: ST_IDLE,
    enable: `COF_RST_EN,
    src: `COF_RST_SRC,
    idx: `COF_RST_IDX,
    pickup: `COF_RST_PICKUP,
    dead_ms: `COF_RST_DEAD_MS,
    win_ms: `COF_RST_WIN_MS,
    nom_a: `COF_RST_NOM_A,
    pick_pri: 32'h00000000,
    trip_cnt: 16'h0000,
    irq_stat: 3'h0,
    irq_mask: 3'h0,
    rdata: 32'h00000000,
    trip: 1'b0,
    irq: 1'b0,
    status: `COF_STAT_BLOCKED,
    tmr_start: 1'b0,
    di_s1: 8'h00,
    di_s2: 8'h00,
    di_s3: 8'h00,
    di_stab: 8'h00
  };

  core_t st_r;
  core_t st_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Timer

  cof_tmr_if tmr_bus();

  assign tmr_bus.start = st_r.tmr_start;
  // Only one interval runs at a time, so the length follows the state
  assign tmr_bus.len_ms = (st_r.state == ST_DEAD) ? st_r.dead_ms : st_r.win_ms;

  cof_ms_timer #(
    .MS_TICK_CYC(MS_TICK_CYC)
  ) u_tmr (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .bus(tmr_bus.tmr)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  logic [15:0] cur_max;
  logic cur_open;
  logic sel_open;
  logic brk_open;
  logic over_pick;
  logic tmr_done;
  logic [2:0] ev;
  logic [31:0] rd_val;

  always_comb begin
    st_nxt = st_r;
    ev = 3'h0;
    rd_val = 32'h00000000;

    // Pin inputs: stable value moves only when stages two and three agree
    st_nxt.di_s1 = i_digital_input_select;
    st_nxt.di_s2 = st_r.di_s1;
    st_nxt.di_s3 = st_r.di_s2;
    for (int i = 0; i < 8; i++) begin
      if (st_r.di_s2[i] == st_r.di_s3[i]) begin
        st_nxt.di_stab[i] = st_r.di_s3[i];
      end
    end

    cur_max = max3(i_cur_l1, i_cur_l2, i_cur_l3);
    cur_open = cur_max < `COF_LOW_LIMIT;
    over_pick = cur_max > st_r.pickup;
    unique case (st_r.src)
      `COF_SRC_DIG: sel_open = st_r.di_stab[st_r.idx];
      `COF_SRC_VIRT: sel_open = i_virtual_input_select[st_r.idx];
      default: sel_open = cur_open;
    endcase
    brk_open = sel_open;
    // Done is stale in the cycle the start is issued
    tmr_done = tmr_bus.done && !st_r.tmr_start;
    st_nxt.tmr_start = 1'b0;

    if (!st_r.enable) begin
      st_nxt.state = ST_IDLE;
    end else begin
      unique case (st_r.state)
        ST_IDLE: begin
          if (brk_open) begin
            st_nxt.state = ST_DEAD;
            st_nxt.tmr_start = 1'b1;
          end
        end
        ST_DEAD: begin
          if (!brk_open || over_pick) begin
            st_nxt.state = ST_IDLE;
          end else if (tmr_done) begin
            st_nxt.state = ST_ARMED;
            ev[`COF_IRQ_ARMED] = 1'b1;
          end
        end
        ST_ARMED: begin
          if (!brk_open) begin
            st_nxt.state = ST_ACTIVE;
            st_nxt.tmr_start = 1'b1;
          end
        end
        ST_ACTIVE: begin
          if (tmr_done) begin
            st_nxt.state = ST_IDLE;
            ev[`COF_IRQ_EXPIRED] = 1'b1;
          end else if (over_pick) begin
            st_nxt.state = ST_TRIP;
            st_nxt.trip_cnt = 16'(st_r.trip_cnt + 16'h0001);
            ev[`COF_IRQ_TRIP] = 1'b1;
          end else if (brk_open) begin
            st_nxt.state = ST_DEAD;
            st_nxt.tmr_start = 1'b1;
          end
        end
        ST_TRIP: begin
          if (brk_open) begin
            st_nxt.state = ST_DEAD;
            st_nxt.tmr_start = 1'b1;
          end
        end
      endcase
    end

    st_nxt.trip = (st_nxt.state == ST_TRIP);
    st_nxt.status = status_of(st_nxt.state);
    st_nxt.pick_pri = st_r.pickup * st_r.nom_a;

    // Register writes
    if (i_wr) begin
      unique case (i_addr)
        `COF_OFS_CTRL: begin
          st_nxt.enable = i_wdata[`COF_CTRL_EN];
          st_nxt.src = i_wdata[`COF_CTRL_SRC_HI:`COF_CTRL_SRC_LO];
          st_nxt.idx = i_wdata[`COF_CTRL_IDX_HI:`COF_CTRL_IDX_LO];
        end
        `COF_OFS_PICKUP: st_nxt.pickup = i_wdata[15:0];
        `COF_OFS_DEAD_DLY: st_nxt.dead_ms = i_wdata[15:0];
        `COF_OFS_ACT_WIN: st_nxt.win_ms = i_wdata[15:0];
        `COF_OFS_NOM_PRI: st_nxt.nom_a = i_wdata[15:0];
        `COF_OFS_IRQ_MASK: st_nxt.irq_mask = i_wdata[2:0];
        default: ;
      endcase
    end
    // Write-one-to-clear; a new event in the same cycle survives
    if (i_wr && i_addr == `COF_OFS_IRQ_STAT) begin
      st_nxt.irq_stat = (st_r.irq_stat & ~i_wdata[2:0]) | ev;
    end else begin
      st_nxt.irq_stat = st_r.irq_stat | ev;
    end
    st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);

    // Register reads, data valid for the following cycle only
    if (i_rd) begin
      unique case (i_addr)
        `COF_OFS_CTRL: rd_val = {26'h0000000, st_r.idx, st_r.src, st_r.enable};
        `COF_OFS_PICKUP: rd_val = {16'h0000, st_r.pickup};
        `COF_OFS_DEAD_DLY: rd_val = {16'h0000, st_r.dead_ms};
        `COF_OFS_ACT_WIN: rd_val = {16'h0000, st_r.win_ms};
        `COF_OFS_NOM_PRI: rd_val = {16'h0000, st_r.nom_a};
        `COF_OFS_PICK_PRI: rd_val = st_r.pick_pri;
        `COF_OFS_STATUS: rd_val = {29'h00000000, brk_open, st_r.status};
        `COF_OFS_TRIP_CNT: rd_val = {16'h0000, st_r.trip_cnt};
        `COF_OFS_IRQ_STAT: rd_val = {29'h00000000, st_r.irq_stat};
        `COF_OFS_IRQ_MASK: rd_val = {29'h00000000, st_r.irq_mask};
        default: rd_val = 32'h00000000;
      endcase
    end
    st_nxt.rdata = rd_val;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_r <= CORE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_rdata = st_r.rdata;
  assign o_trip = st_r.trip;
  assign o_status = st_r.status;
  assign o_irq = st_r.irq;

endmodule // close_onto_fault_trip

/* pkg/cof_defs.svh */
// Purpose: Constants of the close-onto-fault trip stage: offsets, fields, resets, timing.
// Assumes: Currents are magnitudes in milli per-unit of nominal current (1000 = 1.0 x In).
// Notes:   Register offsets are byte addresses of 32-bit words.
// Function
// - Arm only after breaker seen open
// - Current open: max phase below 0.02 In
// - Open may come from digital/virtual input
// - Default open detection is current threshold
// - Arm after open persists dead-line delay 0.20s
// - Over pick-up during dead-line delay: no trip
// - Armed rise above low limit means closure
// - Over pick-up within active window trips
// - No trip after active window expired
// - Trip with no added operate delay
// - Pick-up per-unit 1.5 In, also primary scaled
// - Status: blocked, started or tripped
`ifndef COF_DEFS_SVH
`define COF_DEFS_SVH

// Register offsets
`define COF_OFS_CTRL      8'h00
`define COF_OFS_PICKUP    8'h04
`define COF_OFS_DEAD_DLY  8'h08
`define COF_OFS_ACT_WIN   8'h0C
`define COF_OFS_NOM_PRI   8'h10
`define COF_OFS_PICK_PRI  8'h14
`define COF_OFS_STATUS    8'h18
`define COF_OFS_TRIP_CNT  8'h1C
`define COF_OFS_IRQ_STAT  8'h20
`define COF_OFS_IRQ_MASK  8'h24

// Control fields
`define COF_CTRL_EN       0
`define COF_CTRL_SRC_LO   1
`define COF_CTRL_SRC_HI   2
`define COF_CTRL_IDX_LO   3
`define COF_CTRL_IDX_HI   5

// Dead-line source select codes
`define COF_SRC_NONE      2'h0
`define COF_SRC_DIG       2'h1
`define COF_SRC_VIRT      2'h2

// Status codes
`define COF_STAT_BLOCKED  2'h0
`define COF_STAT_STARTED  2'h1
`define COF_STAT_TRIPPED  2'h2

// Interrupt bits
`define COF_IRQ_TRIP      0
`define COF_IRQ_ARMED     1
`define COF_IRQ_EXPIRED   2

// Reset values
`define COF_RST_EN        1'h1
`define COF_RST_SRC       2'h0
`define COF_RST_IDX       3'h0
`define COF_RST_PICKUP    16'h05DC
`define COF_RST_DEAD_MS   16'h00C8
`define COF_RST_WIN_MS    16'h03E8
`define COF_RST_NOM_A     16'h0064

// Fixed open-detection limit, 0.02 x In in milli per-unit
`define COF_LOW_LIMIT     16'h0014

// Timing
`define COF_CLK_PERIOD_NS 10
`define COF_MS_NS         1000000
`define COF_MS_TICK_CYC   (`COF_MS_NS / `COF_CLK_PERIOD_NS)

`endif

/* pkg/cof_pkg.sv */
// Purpose: Types of the close-onto-fault trip stage.
// Assumes: cof_defs.svh holds the numbers.
// Notes:   Packed state structs follow the one-comb one-ff idiom.
package cof_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEAD,
    ST_ARMED,
    ST_ACTIVE,
    ST_TRIP
  } fsm_t;

  typedef struct packed {
    fsm_t        state;
    logic        enable;
    logic [1:0]  src;
    logic [2:0]  idx;
    logic [15:0] pickup;
    logic [15:0] dead_ms;
    logic [15:0] win_ms;
    logic [15:0] nom_a;
    logic [31:0] pick_pri;
    logic [15:0] trip_cnt;
    logic [2:0]  irq_stat;
    logic [2:0]  irq_mask;
    logic [31:0] rdata;
    logic        trip;
    logic        irq;
    logic [1:0]  status;
    logic        tmr_start;
    logic [7:0]  di_s1;
    logic [7:0]  di_s2;
    logic [7:0]  di_s3;
    logic [7:0]  di_stab;
  } core_t;

  typedef struct packed {
    logic [16:0] pre;
    logic [15:0] elapsed;
    logic        running;
    logic        done;
  } tmr_t;

endpackage

/* pkg/cof_tmr_if.sv */
// Purpose: Link between the stage sequencer and its millisecond timer.
// Assumes: One clock domain.
// Notes:   done is a level, cleared by the next start.
`timescale 1ns/1ps
interface cof_tmr_if;
  logic start;
  logic [15:0] len_ms;
  logic done;
  modport ctl (output start, output len_ms, input done);
  modport tmr (input start, input len_ms, output done);
endinterface

/* rtl/cof_ms_timer.sv */
// Purpose: Millisecond interval timer for dead-line delay and active window.
// Assumes: len_ms stable while running.
// Notes:   A start restarts the interval; done holds until the next start.
`timescale 1ns/1ps
`include "cof_defs.svh"
module cof_ms_timer
  import cof_pkg::*;
#(
  parameter int unsigned MS_TICK_CYC = `COF_MS_TICK_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Sequencer side
  cof_tmr_if.tmr bus
);

  tmr_t tm_r;
  tmr_t tm_nxt;

  always_comb begin
    tm_nxt = tm_r;
    if (bus.start) begin
      tm_nxt.pre = 17'h00000;
      tm_nxt.elapsed = 16'h0000;
      tm_nxt.running = 1'b1;
      tm_nxt.done = 1'b0;
    end else if (tm_r.running) begin
      if (tm_r.pre == 17'(MS_TICK_CYC - 1)) begin
        tm_nxt.pre = 17'h00000;
        tm_nxt.elapsed = 16'(tm_r.elapsed + 16'h0001);
        // A zero length still waits one full millisecond
        if (16'(tm_r.elapsed + 16'h0001) >= bus.len_ms) begin
          tm_nxt.running = 1'b0;
          tm_nxt.done = 1'b1;
        end
      end else begin
        tm_nxt.pre = 17'(tm_r.pre + 17'h00001);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      tm_r <= '0;
    end else begin
      tm_r <= tm_nxt;
    end
  end

  assign bus.done = tm_r.done;

endmodule // cof_ms_timer

/* verification/cof_checker.sv */
// Purpose: Port-level checks of the close-onto-fault stage.
// Assumes: Settings are shadowed from register writes seen at the port.
// Notes: A fault in the very cycle the window expires is not covered.
`timescale 1ns/1ps
`include "cof_defs.svh"
module cof_checker #(
  parameter int unsigned MS_TICK_CYC = 10
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  // Currents
  input wire logic [15:0] i_cur_l1,
  input wire logic [15:0] i_cur_l2,
  input wire logic [15:0] i_cur_l3,
  // Results
  input wire logic o_trip,
  input wire logic [1:0] o_status,
  input wire logic o_irq
);
  logic [15:0] cmax;
  logic [15:0] pick_r;
  logic [15:0] dead_r;
  logic [2:0] ctrl_r;
  logic [2:0] mask_r;
  logic [31:0] open_r;
  logic [31:0] dead_cyc;
  logic cur_mode;
  logic cur_high;
  logic cur_open;
  always_comb begin
    cmax = (i_cur_l1 > i_cur_l2) ? i_cur_l1 : i_cur_l2;
    cmax = (i_cur_l3 > cmax) ? i_cur_l3 : cmax;
  end
  // Source codes 0 and 3 both mean current detection
  assign cur_mode = ctrl_r[0] && (ctrl_r[2] == ctrl_r[1]);
  assign cur_high = cmax > pick_r;
  assign cur_open = cmax < `COF_LOW_LIMIT;
  assign dead_cyc = ((dead_r == 16'h0) ? 32'h1 : {16'h0, dead_r}) * MS_TICK_CYC;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pick_r <= `COF_RST_PICKUP;
      dead_r <= `COF_RST_DEAD_MS;
      ctrl_r <= 3'h1;
      mask_r <= 3'h0;
    end else if (i_wr) begin
      case (i_addr)
        `COF_OFS_CTRL: ctrl_r <= i_wdata[2:0];
        `COF_OFS_PICKUP: pick_r <= i_wdata[15:0];
        `COF_OFS_DEAD_DLY: dead_r <= i_wdata[15:0];
        `COF_OFS_IRQ_MASK: mask_r <= i_wdata[2:0];
        default: ;
      endcase
    end
    open_r <= (!i_rst_n || !cur_open) ? 32'h0 : open_r + 32'h1;
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_started_over;
    (o_status == `COF_STAT_STARTED) && cur_high && cur_mode;
  endsequence
  sequence s_over_held;
    s_started_over ##1 cur_high;
  endsequence
  AST_STATUS_CODE: assert property (o_status != 2'h3)
    else $error("status code out of range");
  AST_TRIP_STATUS: assert property (o_trip == (o_status == `COF_STAT_TRIPPED))
    else $error("trip and status disagree");
  AST_TRIP_FROM_STARTED: assert property ($rose(o_trip) |-> $past(o_status) == `COF_STAT_STARTED)
    else $error("trip without armed stage");
  AST_TRIP_CAUSE: assert property ($rose(o_trip) |-> $past(cur_high))
    else $error("trip without over pick-up current");
  AST_TRIP_FAST: assert property (s_over_held |-> ##[0:1] o_trip)
    else $error("trip delayed");
  AST_ARM_DELAY: assert property (cur_mode && $past(o_status) == `COF_STAT_BLOCKED
    && o_status == `COF_STAT_STARTED |-> open_r >= dead_cyc)
    else $error("armed before dead-line delay");
  AST_TRIP_RELEASE: assert property (o_trip && cur_mode && cur_open |=> !o_trip)
    else $error("trip held with breaker open");
  AST_IRQ_MASKED: assert property ((mask_r == 3'h0) [*2] |-> !o_irq)
    else $error("interrupt while fully masked");
  AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data outside read slot");
endmodule // cof_checker

bind close_onto_fault_trip cof_checker #(.MS_TICK_CYC(MS_TICK_CYC)) cof_checker_inst (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .i_cur_l1(i_cur_l1), .i_cur_l2(i_cur_l2), .i_cur_l3(i_cur_l3),
  .o_trip(o_trip), .o_status(o_status), .o_irq(o_irq));

/* verification/cof_breaker_model.sv */
// Purpose: Breaker and current front end facing the stage.
// Assumes: One sample per clock, milli per-unit magnitudes.
// Notes: Open breaker leaves wandering residue just under the low limit.
`timescale 1ns/1ps
module cof_breaker_model (
  // Clock
  input wire logic i_clk,
  // Commands
  input wire logic i_close,
  input wire logic [15:0] i_load,
  input wire logic [1:0] i_phase,
  // Measurements
  output logic [15:0] o_cur_l1,
  output logic [15:0] o_cur_l2,
  output logic [15:0] o_cur_l3,
  output logic [7:0] o_dig_open
);
  logic [1:0] noise_r = 2'h0;
  always_ff @(posedge i_clk) begin
    noise_r <= noise_r + 2'h1;
    // Residue up to 19 probes the limit boundary
    o_cur_l1 <= !i_close ? 16'h0010 + noise_r : (i_phase == 2'h0) ? i_load : 16'h0015;
    o_cur_l2 <= !i_close ? 16'h0013 - noise_r : (i_phase == 2'h1) ? i_load : 16'h0015;
    o_cur_l3 <= !i_close ? 16'h0011 : (i_phase == 2'h2) ? i_load : 16'h0015;
    // Bit 3 is the breaker contact, the others toggle
    o_dig_open <= {{4{noise_r[0]}}, !i_close, {3{noise_r[1]}}};
  end
endmodule // cof_breaker_model

/* verification/close_onto_fault_trip_tb.sv */
// Purpose: Self-checking bench of the close-onto-fault stage.
// Assumes: Millisecond shortened to 10 cycles.
// Notes: Delays set to 5 ms dead line and 8 ms window.
`timescale 1ns/1ps
`include "cof_defs.svh"
module close_onto_fault_trip_tb;
  logic i_clk;
  logic i_rst_n;
  logic [7:0] i_addr;
  logic [31:0] i_wdata;
  logic i_wr;
  logic i_rd;
  logic [31:0] o_rdata;
  logic [15:0] cur1;
  logic [15:0] cur2;
  logic [15:0] cur3;
  logic [7:0] din;
  logic [7:0] vin;
  logic o_trip;
  logic [1:0] o_status;
  logic o_irq;
  logic close;
  logic [15:0] load;
  logic [1:0] phase;
  int err_count = 0;
  int checked = 0;
  int n;
  cof_breaker_model cof_breaker_model_inst (.i_clk(i_clk), .i_close(close), .i_load(load),
    .i_phase(phase), .o_cur_l1(cur1), .o_cur_l2(cur2), .o_cur_l3(cur3), .o_dig_open(din));
  close_onto_fault_trip #(.MS_TICK_CYC(10)) close_onto_fault_trip_inst (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_cur_l1(cur1), .i_cur_l2(cur2), .i_cur_l3(cur3),
    .i_digital_input_select(din), .i_virtual_input_select(vin), .o_trip(o_trip),
    .o_status(o_status), .o_irq(o_irq));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk(name, exp, o_rdata);
  endtask
  task automatic wait_stat(input logic [1:0] code, input int lim, output int k);
    k = 0;
    while (o_status !== code) begin
      if (k == lim) begin
        err_count++;
        $display("CHECK FAILED status_wait expected %h seen %h", code, o_status);
        finish_test();
      end else begin
        step(1);
        k++;
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  initial begin
    i_rst_n = 1'b0;
    i_addr = 8'h00;
    i_wdata = 32'h0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    vin = 8'h00;
    close = 1'b1;
    load = 16'h01F4;
    phase = 2'h0;
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd(8'h00, 32'h1, "ctrl");
    rd(8'h04, 32'h5DC, "pickup");
    rd(8'h08, 32'hC8, "dead_dly");
    rd(8'h0C, 32'h3E8, "act_win");
    rd(8'h14, 32'h249F0, "pick_pri");
    rd(8'h1C, 32'h0, "trip_cnt");
    rd(8'h18, 32'h0, "status");
    rd(8'h30, 32'h0, "unmapped");
    wr(8'h10, 32'hC8);
    wr(8'h08, 32'h5);
    wr(8'h0C, 32'h8);
    wr(8'h24, 32'h7);
    rd(8'h14, 32'h493E0, "pick_pri_scaled");
    close <= 1'b0;
    wait_stat(`COF_STAT_STARTED, 200, n);
    chk("arm_time", 1, n >= 50 && n <= 60);
    chk("irq_armed", 1, o_irq);
    rd(8'h20, 32'h2, "irq_stat_armed");
    wr(8'h20, 32'h2);
    step(2);
    chk("irq_cleared", 0, o_irq);
    rd(8'h18, 32'h5, "status_open");
    @(posedge i_clk);
    load <= 16'h05DC;
    phase <= 2'h1;
    close <= 1'b1;
    step(5);
    chk("no_trip_at_pickup", 0, o_trip);
    @(posedge i_clk);
    load <= 16'h05DD;
    phase <= 2'h2;
    step(1);
    chk("trip_early", 0, o_trip);
    step(1);
    chk("trip", 1, o_trip);
    rd(8'h1C, 32'h1, "trip_cnt_one");
    rd(8'h20, 32'h1, "irq_stat_trip");
    wr(8'h20, 32'h1);
    close <= 1'b0;
    wait_stat(`COF_STAT_STARTED, 200, n);
    chk("trip_released", 0, o_trip);
    @(posedge i_clk);
    load <= 16'h0014;
    phase <= 2'h0;
    close <= 1'b1;
    wait_stat(`COF_STAT_BLOCKED, 200, n);
    chk("window_time", 1, n >= 80 && n <= 90);
    @(posedge i_clk);
    load <= 16'h0BB8;
    step(4);
    chk("no_trip_after_window", 0, o_trip);
    // Armed bit set again by the re-arm after the trip was cleared
    rd(8'h20, 32'h6, "irq_stat_expired");
    close <= 1'b0;
    step(20);
    @(posedge i_clk);
    close <= 1'b1;
    step(100);
    chk("no_trip_short_open", 0, o_trip);
    wr(8'h00, 32'h2D);
    close <= 1'b0;
    step(80);
    chk("virtual_not_open", `COF_STAT_BLOCKED, o_status);
    vin <= 8'h20;
    wait_stat(`COF_STAT_STARTED, 200, n);
    vin <= 8'h00;
    wait_stat(`COF_STAT_BLOCKED, 200, n);
    wr(8'h00, 32'h1B);
    wait_stat(`COF_STAT_STARTED, 200, n);
    @(posedge i_clk);
    close <= 1'b1;
    wait_stat(`COF_STAT_TRIPPED, 20, n);
    chk("digital_trip", 1, o_trip);
    rd(8'h1C, 32'h2, "trip_cnt_two");
    finish_test();
  end
endmodule // close_onto_fault_trip_tb
